// file: include/psv_pkg.sv
// constants and helpers for the per-port slot and VC preload loader
// What this block does
// - port 1 word at 62h, port 2 at 64h, port 3 at 66h, port 4 at 68h
// - word bit 0 goes to bit 24 of dword C0h, slot implemented
// - word bit 1 goes to bit 28 of dword D0h, connector clock used
// - word bit 2 goes to bit 21 of dword 40h, special init required
// - word bit 3 goes to bit 4 of dword port_vc_capability_one, VC1 is low priority
// - word bits 6:4 go to bits 26:24 of dword Link_capability_dword, logical port number
// - word bits 15:9 go to bits 7:1 of dword vc0_resource_control, TC to VC0 map
// - port 0 word at 60h uses same layout, without slot-implemented bit
package psv_pkg;

  localparam int unsigned NUM_PORTS = 5;
  localparam logic [2:0] LAST_PORT = 3'h4;

  // configuration memory word addresses
  localparam logic [7:0] PRE_ADDR_P0 = 8'h60;
  localparam logic [7:0] PRE_ADDR_P1 = 8'h62;
  localparam logic [7:0] PRE_ADDR_P2 = 8'h64;
  localparam logic [7:0] PRE_ADDR_P3 = 8'h66;
  localparam logic [7:0] PRE_ADDR_P4 = 8'h68;

  // configuration dword offsets
  localparam logic [11:0] OFF_PM_CAP = 12'h040;
  localparam logic [11:0] OFF_EXP_CAP = 12'h0C0;
  localparam logic [11:0] OFF_LINK_CAP = 12'h0CC;
  localparam logic [11:0] OFF_LINK_CTL = 12'h0D0;
  localparam logic [11:0] OFF_VC_CAP1 = 12'h144;
  localparam logic [11:0] OFF_VC0_CTL = 12'h154;

  // field positions in the preload word
  localparam int unsigned WB_SLOT = 0;
  localparam int unsigned WB_CLK = 1;
  localparam int unsigned WB_DSI = 2;
  localparam int unsigned WB_LPVC = 3;
  localparam int unsigned WB_PNUM = 4;
  localparam int unsigned WB_TC = 9;
  // field positions in the configuration dwords
  localparam int unsigned CB_SLOT = 24;
  localparam int unsigned CB_CLK = 28;
  localparam int unsigned CB_DSI = 21;
  localparam int unsigned CB_LPVC = 4;
  localparam int unsigned CB_PNUM = 24;
  localparam int unsigned CB_TC = 1;
  localparam int unsigned PNUM_W = 3;
  localparam int unsigned TC_W = 7;

  // values after reset
  localparam logic [15:0] PRE_DEFAULT = 16'h0000;
  localparam logic [31:0] CFG_DATA_RESET = 32'h0000_0000;
  localparam logic [2:0] IDX_RESET = 3'h0;
  localparam logic [7:0] REQ_ADDR_RESET = 8'h00;
  localparam logic [11:0] CFG_ADDR_RESET = 12'h000;

  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_ISSUE = 4'h2,
    ST_FETCH = 4'h4,
    ST_DONE = 4'h8
  } psv_state_type;

  // default word: all flags clear, logical number equals physical number
  function automatic logic [15:0] pre_default(input logic [2:0] port);
    logic [15:0] w;
    w = PRE_DEFAULT;
    w[WB_PNUM +: PNUM_W] = port;
    return w;
  endfunction

  function automatic logic [7:0] word_addr(input logic [2:0] port);
    logic [7:0] a;
    a = PRE_ADDR_P0;
    case (port)
      3'h1: a = PRE_ADDR_P1;
      3'h2: a = PRE_ADDR_P2;
      3'h3: a = PRE_ADDR_P3;
      3'h4: a = PRE_ADDR_P4;
      default: a = PRE_ADDR_P0;
    endcase
    return a;
  endfunction

  // places the preload fields of one port into the addressed dword
  function automatic logic [31:0] cfg_dword(input logic [15:0] w,
                                            input logic [11:0] off,
                                            input logic [2:0] port);
    logic [31:0] d;
    d = CFG_DATA_RESET;
    case (off)
      OFF_EXP_CAP:
        if (port != 3'h0)
          d[CB_SLOT] = w[WB_SLOT];
      OFF_LINK_CTL: d[CB_CLK] = w[WB_CLK];
      OFF_PM_CAP: d[CB_DSI] = w[WB_DSI];
      OFF_VC_CAP1: d[CB_LPVC] = w[WB_LPVC];
      OFF_LINK_CAP: d[CB_PNUM +: PNUM_W] = w[WB_PNUM +: PNUM_W];
      OFF_VC0_CTL: d[CB_TC +: TC_W] = w[WB_TC +: TC_W];
      default: d = CFG_DATA_RESET;
    endcase
    if (port > LAST_PORT)
      d = CFG_DATA_RESET;
    return d;
  endfunction

endpackage

// file: rtl/psv_word_mem.sv
// five-entry store of per-port preload words with registered read
`timescale 1ns/1ps
module psv_word_mem
  import psv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [15:0] rd_data
);

  logic [15:0] mem [0:NUM_PORTS-1];
  logic [15:0] rd_data_reg;

  always_ff @(posedge clk)
  begin
    if (ce && wr_en && wr_idx <= LAST_PORT)
    begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data_reg <= PRE_DEFAULT;
    end
    else if (ce)
    begin
      rd_data_reg <= (rd_idx <= LAST_PORT) ? mem[rd_idx] : PRE_DEFAULT;
    end
  end

  assign rd_data = rd_data_reg;

endmodule

// file: rtl/psv_preload_map.sv
// preload loader and per-port configuration field read port
`timescale 1ns/1ps
module psv_preload_map
  import psv_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic MEM_PRESENT,
  output logic REQ_VALID,
  output logic [7:0] REQ_ADDR,
  input wire logic RSP_VALID,
  input wire logic [15:0] RSP_DATA,
  input wire logic CFG_RD,
  input wire logic [2:0] CFG_PORT,
  input wire logic [11:0] CFG_ADDR,
  output logic CFG_READY,
  output logic CFG_RD_VALID,
  output logic [31:0] CFG_RD_DATA
);

  psv_state_type state_reg;
  logic [2:0] idx_reg;
  logic mem_used_reg;
  logic req_valid_reg;
  logic [7:0] req_addr_reg;
  logic ready_reg;
  logic s1_valid_reg;
  logic [11:0] s1_addr_reg;
  logic [2:0] s1_port_reg;
  logic rd_valid_reg;
  logic [31:0] rd_data_reg;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_word;
  logic rsp_take;

  assign rsp_take = (state_reg == ST_FETCH) && RSP_VALID;

  // defaults first, then memory words overwrite them
  always_comb
  begin
    wr_en = 1'b0;
    wr_data = pre_default(idx_reg);
    if (state_reg == ST_INIT)
    begin
      wr_en = 1'b1;
    end
    else if (rsp_take)
    begin
      wr_en = 1'b1;
      wr_data = RSP_DATA;
    end
  end

  psv_word_mem u_mem (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .ce(CE),
    .wr_en(wr_en),
    .wr_idx(idx_reg),
    .wr_data(wr_data),
    .rd_idx(CFG_PORT),
    .rd_data(rd_word)
  );

  // load sequence
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      state_reg <= ST_INIT;
      idx_reg <= IDX_RESET;
      mem_used_reg <= 1'b0;
    end
    else if (CE)
    begin
      unique case (state_reg)
        ST_INIT:
        begin
          if (idx_reg == LAST_PORT)
          begin
            idx_reg <= IDX_RESET;
            mem_used_reg <= MEM_PRESENT;
            state_reg <= MEM_PRESENT ? ST_ISSUE : ST_DONE;
          end
          else
          begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        ST_ISSUE:
        begin
          state_reg <= ST_FETCH;
        end
        ST_FETCH:
        begin
          if (RSP_VALID)
          begin
            if (idx_reg == LAST_PORT)
            begin
              state_reg <= ST_DONE;
            end
            else
            begin
              idx_reg <= idx_reg + 3'h1;
              state_reg <= ST_ISSUE;
            end
          end
        end
        ST_DONE:
        begin
          state_reg <= ST_DONE;
        end
      endcase
    end
  end

  // word fetch request toward the configuration memory
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      req_valid_reg <= 1'b0;
      req_addr_reg <= REQ_ADDR_RESET;
    end
    else if (CE)
    begin
      if (state_reg == ST_ISSUE)
      begin
        req_valid_reg <= 1'b1;
        req_addr_reg <= word_addr(idx_reg);
      end
      else if (rsp_take)
      begin
        req_valid_reg <= 1'b0;
      end
    end
  end

  // fields go visible only once loading is over
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      ready_reg <= 1'b0;
    end
    else if (CE)
    begin
      ready_reg <= (state_reg == ST_DONE);
    end
  end

  // read pipeline: word fetch, then field placement
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      s1_valid_reg <= 1'b0;
      s1_addr_reg <= CFG_ADDR_RESET;
      s1_port_reg <= IDX_RESET;
    end
    else if (CE)
    begin
      s1_valid_reg <= CFG_RD && ready_reg;
      if (CFG_RD)
      begin
        s1_addr_reg <= CFG_ADDR;
        s1_port_reg <= CFG_PORT;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= CFG_DATA_RESET;
    end
    else if (CE)
    begin
      rd_valid_reg <= s1_valid_reg;
      if (s1_valid_reg)
      begin
        rd_data_reg <= cfg_dword(rd_word, s1_addr_reg, s1_port_reg);
      end
    end
  end

  assign REQ_VALID = req_valid_reg;
  assign REQ_ADDR = req_addr_reg;
  assign CFG_READY = ready_reg;
  assign CFG_RD_VALID = rd_valid_reg;
  assign CFG_RD_DATA = rd_data_reg;

  // checking helpers: copy of stored words and address of the answer
  logic [15:0] chk_word [0:NUM_PORTS-1];
  logic [11:0] chk_addr;
  logic [2:0] chk_port;
  logic [15:0] chk_cur;

  always_ff @(posedge CLK_SYS)
  begin
    if (CE && wr_en)
    begin
      chk_word[idx_reg] <= wr_data;
    end
    if (CE && s1_valid_reg)
    begin
      chk_addr <= s1_addr_reg;
      chk_port <= s1_port_reg;
    end
  end

  assign chk_cur = (chk_port <= LAST_PORT) ? chk_word[chk_port] : PRE_DEFAULT;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  sequence s_rd_taken;
    CFG_RD && CFG_READY && CE;
  endsequence

  sequence s_fetch_done;
    REQ_VALID && RSP_VALID && CE && state_reg == ST_FETCH;
  endsequence

  a_fetch_addr: assert property (
    (REQ_VALID && idx_reg == 3'h4) |-> REQ_ADDR == PRE_ADDR_P4)
    else $error("port 4 word fetched from wrong address");

  // word addresses step by two from the port 0 word
  a_fetch_any: assert property (
    REQ_VALID |-> REQ_ADDR == PRE_ADDR_P0 + {4'h0, idx_reg, 1'b0})
    else $error("word fetched from address of another port");

  a_slot_impl: assert property (
    (CFG_RD_VALID && chk_addr == OFF_EXP_CAP && chk_port != 3'h0
      && chk_port <= LAST_PORT)
    |-> CFG_RD_DATA[CB_SLOT] == chk_cur[WB_SLOT])
    else $error("slot implemented bit does not follow word bit 0");

  a_slot_clock: assert property (
    (CFG_RD_VALID && chk_addr == OFF_LINK_CTL && chk_port <= LAST_PORT)
    |-> CFG_RD_DATA[CB_CLK] == chk_cur[WB_CLK])
    else $error("slot clock bit does not follow word bit 1");

  a_dsi_flag: assert property (
    (CFG_RD_VALID && chk_addr == OFF_PM_CAP && chk_port <= LAST_PORT)
    |-> CFG_RD_DATA[CB_DSI] == chk_cur[WB_DSI])
    else $error("init required bit does not follow word bit 2");

  a_lpvc_count: assert property (
    (CFG_RD_VALID && chk_addr == OFF_VC_CAP1 && chk_port <= LAST_PORT)
    |-> CFG_RD_DATA[CB_LPVC] == chk_cur[WB_LPVC])
    else $error("low priority VC bit does not follow word bit 3");

  a_port_number: assert property (
    (CFG_RD_VALID && chk_addr == OFF_LINK_CAP && chk_port <= LAST_PORT)
    |-> CFG_RD_DATA[26:24] == chk_cur[6:4])
    else $error("logical port number does not follow word bits 6:4");

  a_tc_map: assert property (
    (CFG_RD_VALID && chk_addr == OFF_VC0_CTL && chk_port <= LAST_PORT)
    |-> CFG_RD_DATA[7:1] == chk_cur[15:9] && !CFG_RD_DATA[0])
    else $error("TC map does not follow word bits 15:9");

  a_port0_word: assert property (
    ((REQ_VALID && idx_reg == 3'h0) |-> REQ_ADDR == PRE_ADDR_P0)
    and ((CFG_RD_VALID && chk_port == 3'h0 && chk_addr == OFF_EXP_CAP)
      |-> CFG_RD_DATA == CFG_DATA_RESET))
    else $error("port 0 word address or slot bit wrong");

  a_read_gated: assert property (
    (!CFG_READY |-> !s1_valid_reg && !CFG_RD_VALID)
    and (s_rd_taken ##1 CE |=> CFG_RD_VALID))
    else $error("read answered while loading or answer missing");

  a_fetch_order: assert property (
    (s_fetch_done ##0 idx_reg != LAST_PORT)
    |=> !REQ_VALID and (CE |=> REQ_VALID
      && REQ_ADDR == $past(REQ_ADDR) + 8'h02))
    else $error("request not paused or not advanced after response");

  a_no_memory: assert property (
    (state_reg == ST_DONE && !mem_used_reg)
    |-> chk_word[1] == pre_default(3'h1) && !REQ_VALID)
    else $error("defaults lost without configuration memory");

  // apart from reset, nothing moves while the clock enable is low
  a_ce_freeze: assert property (
    !CE |=> $stable(state_reg) && $stable(REQ_VALID)
      && $stable(CFG_RD_VALID) && $stable(CFG_READY))
    else $error("state moved while clock enable low");

  a_ready_hold: assert property (
    CFG_READY |=> CFG_READY)
    else $error("fields hidden again after loading");

endmodule

// file: dv/psv_mem_model.sv
// behavioural configuration memory answering preload word fetches
`timescale 1ns/1ps
module psv_mem_model
  import psv_pkg::*;
(
  input wire logic clk,
  input wire logic [79:0] words,
  input wire logic [3:0] lat,
  input wire logic req_valid,
  input wire logic [7:0] req_addr,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  logic [3:0] wait_reg;
  logic [2:0] idx;
  assign idx = 3'((req_addr - PRE_ADDR_P0) >> 1);
  initial
  begin
    rsp_valid = 1'b0;
    rsp_data = 16'h0000;
    wait_reg = 4'h0;
  end
  // level answer held until the request drops; data churns when idle
  always @(posedge clk)
  begin
    if (!req_valid)
    begin
      wait_reg <= 4'h0;
      rsp_valid <= 1'b0;
      rsp_data <= ~rsp_data;
    end
    else if (wait_reg < lat)
    begin
      wait_reg <= wait_reg + 4'h1;
      rsp_data <= ~rsp_data;
    end
    else
    begin
      rsp_valid <= 1'b1;
      rsp_data <= words[idx*16 +: 16];
    end
  end
endmodule

// file: dv/tb_port_slot_vc_preload_map.sv
// self-checking bench for the preload loader
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_port_slot_vc_preload_map
  import psv_pkg::*;
();
  typedef struct {
    logic [2:0] p;
    logic [11:0] a;
    logic [31:0] e;
  } psv_row_type;
  logic CLK_SYS = 1'b0;
  logic RESETN = 1'b0;
  logic CE = 1'b1;
  logic MEM_PRESENT = 1'b0;
  logic CFG_RD = 1'b0;
  logic [2:0] CFG_PORT = 3'h0;
  logic [11:0] CFG_ADDR = 12'h000;
  logic REQ_VALID, RSP_VALID, CFG_READY, CFG_RD_VALID;
  logic req_q = 1'b0;
  logic [7:0] REQ_ADDR;
  logic [15:0] RSP_DATA;
  logic [31:0] CFG_RD_DATA;
  logic [3:0] lat = 4'h0;
  logic [79:0] words = 80'h0180_002C_8152_0201_FE7F;
  logic [31:0] got[$];
  logic [7:0] addrs[$];
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  psv_row_type rows[20] = '{
    '{3'h0, 12'h0C0, 32'h0}, '{3'h0, 12'h0D0, 32'h1000_0000},
    '{3'h0, 12'h040, 32'h0020_0000}, '{3'h0, 12'h144, 32'h10},
    '{3'h0, 12'h0CC, 32'h0700_0000}, '{3'h0, 12'h154, 32'hFE},
    '{3'h1, 12'h0C0, 32'h0100_0000}, '{3'h1, 12'h154, 32'h2},
    '{3'h1, 12'h048, 32'h0}, '{3'h2, 12'h0D0, 32'h1000_0000},
    '{3'h2, 12'h0CC, 32'h0500_0000}, '{3'h2, 12'h154, 32'h80},
    '{3'h2, 12'h040, 32'h0}, '{3'h3, 12'h040, 32'h0020_0000},
    '{3'h3, 12'h144, 32'h10}, '{3'h3, 12'h0CC, 32'h0200_0000},
    '{3'h4, 12'h0CC, 32'h0}, '{3'h4, 12'h154, 32'h0},
    '{3'h4, 12'h0C0, 32'h0}, '{3'h5, 12'h0C0, 32'h0}};

  always #12.5 CLK_SYS = ~CLK_SYS;

  psv_preload_map u_psv_preload_map (.CLK_SYS, .RESETN, .CE,
    .MEM_PRESENT, .REQ_VALID, .REQ_ADDR, .RSP_VALID, .RSP_DATA, .CFG_RD,
    .CFG_PORT, .CFG_ADDR, .CFG_READY, .CFG_RD_VALID, .CFG_RD_DATA);
  psv_mem_model u_psv_mem_model (.clk(CLK_SYS), .words, .lat,
    .req_valid(REQ_VALID), .req_addr(REQ_ADDR), .rsp_valid(RSP_VALID),
    .rsp_data(RSP_DATA));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (CFG_RD_VALID === 1'b1)
      got.push_back(CFG_RD_DATA);
    if (REQ_VALID === 1'b1 && req_q !== 1'b1)
      addrs.push_back(REQ_ADDR);
    req_q <= REQ_VALID;
    if (cycles == 6000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic tick(int n);
    repeat (n) @(posedge CLK_SYS);
    #2;
  endtask

  task automatic do_reset(logic mem, logic [3:0] l);
    RESETN = 1'b0;
    MEM_PRESENT = mem;
    lat = l;
    tick(4);
    RESETN = 1'b1;
    got.delete();
    addrs.delete();
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 400 && CFG_READY !== 1'b1; i++)
      tick(1);
  endtask

  task automatic rd(logic [2:0] p, logic [11:0] a);
    CFG_RD = 1'b1;
    CFG_PORT = p;
    CFG_ADDR = a;
    tick(1);
  endtask

  task automatic check_addrs();
    `CHK(addrs.size(), 5)
    foreach (addrs[i])
      `CHK(addrs[i], 8'h60 + 8'(2 * i))
  endtask

  initial
  begin
    // no memory: early read dropped, defaults kept
    do_reset(1'b0, 4'h0);
    rd(3'h1, OFF_LINK_CAP);
    CFG_RD = 1'b0;
    `CHK(CFG_READY, 1'b0)
    wait_ready();
    tick(3);
    `CHK(got.size(), 0)
    `CHK(addrs.size(), 0)
    rd(3'h3, OFF_LINK_CAP);
    CFG_RD = 1'b0;
    `CHK(CFG_RD_VALID, 1'b0)
    tick(1);
    `CHK(CFG_RD_VALID, 1'b1)
    `CHK(CFG_RD_DATA, 32'h0300_0000)
    tick(1);
    `CHK(CFG_RD_VALID, 1'b0)
    // prompt memory, back-to-back reads over the table
    do_reset(1'b1, 4'h0);
    wait_ready();
    foreach (rows[i])
      rd(rows[i].p, rows[i].a);
    CFG_RD = 1'b0;
    tick(3);
    check_addrs();
    `CHK(got.size(), 20)
    foreach (rows[i])
      `CHK(got[i], rows[i].e)
    // slow memory with clock enable dropped mid-load
    do_reset(1'b1, 4'h6);
    tick(11);
    CE = 1'b0;
    tick(5);
    CE = 1'b1;
    // answer arrived during the freeze and is still pending
    `CHK(REQ_VALID, 1'b1)
    `CHK(RSP_VALID, 1'b1)
    wait_ready();
    rd(3'h2, OFF_LINK_CAP);
    rd(3'h4, OFF_EXP_CAP);
    CFG_RD = 1'b0;
    tick(3);
    check_addrs();
    `CHK(got[0], 32'h0500_0000)
    `CHK(got[1], 32'h0)
    finish_test();
  end
endmodule
